// ===== verilog/nvmtc_pkg.sv
// Shared constants for the nonvolatile store and reload down-counter block
package nvmtc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] NVMTC_ADDR_OFS   = 8'h01;  // Storage address
  localparam logic [7:0] NVMTC_DATA_OFS   = 8'h03;  // Storage data window
  localparam logic [7:0] NVMTC_CTRL_OFS   = 8'h04;  // nvm_timer_control
  localparam logic [7:0] NVMTC_RELOAD_OFS = 8'h05;  // Counter reload value
  localparam logic [7:0] NVMTC_COUNT_OFS  = 8'h06;  // Counter value, read only

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int NVMTC_RUN_BIT  = 7;
  localparam int NVMTC_IEN_BIT  = 6;
  localparam int NVMTC_FLAG_BIT = 5;
  localparam int NVMTC_PROG_BIT = 4;
  localparam int NVMTC_MODE_LSB = 1;
  localparam int NVMTC_MODE_MSB = 3;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NVMTC_BYTES      = 256;
  localparam int NVMTC_PAGES      = 64;
  localparam int NVMTC_PAGE_BYTES = 4;

  // ----------------------------------------------------------------
  // Mode codes (program bit excluded)
  // ----------------------------------------------------------------
  localparam logic [2:0] NVMTC_MODE_READ   = 3'h0;
  localparam logic [2:0] NVMTC_MODE_INCR   = 3'h2;
  localparam logic [2:0] NVMTC_MODE_ERWR   = 3'h4;
  localparam logic [2:0] NVMTC_MODE_ERASE  = 3'h7;
  localparam logic [1:0] NVMTC_MODE_WRPAGE = 2'h1;  // Upper two mode bits

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int NVMTC_CLK_MHZ    = 25;
  localparam int NVMTC_TICK_NS    = 20000;
  localparam int NVMTC_TICK_CYC   = NVMTC_TICK_NS * NVMTC_CLK_MHZ / 1000;
  localparam int NVMTC_CYCLE_US   = 5;
  localparam int NVMTC_CYCLE_MS   = NVMTC_CYCLE_US;
  localparam int NVMTC_RELOAD_DEF = NVMTC_CYCLE_MS * 1000000 / NVMTC_TICK_NS;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] NVMTC_CTRL_RST   = 8'h00;
  localparam logic [7:0] NVMTC_RELOAD_RST = NVMTC_RELOAD_DEF[7:0];

  // Cycle sequencer
  typedef enum logic [1:0] {
    NVMTC_PH_IDLE   = 2'b00,
    NVMTC_PH_FIRST  = 2'b01,
    NVMTC_PH_SECOND = 2'b11
  } nvmtc_phase_t;

endpackage

// ===== verilog/nvmtc_store.sv
// Byte array of the nonvolatile store with page erase and OR-write
`timescale 1ns/1ps
module nvmtc_store
  import nvmtc_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic [7:0]  raddr_i,
  output logic      [7:0]  rdata_o,
  input  wire logic [5:0]  page_i,
  input  wire logic [3:0]  erase_i,
  input  wire logic [3:0]  write_i,
  input  wire logic [31:0] data_i
);

  logic [7:0] mem [NVMTC_BYTES];

  // Asynchronous read port
  assign rdata_o = mem[raddr_i];

  // ----------------------------------------------------------------
  // Page update: erase clears, write ORs, both copy latches
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    for (int b = 0; b < NVMTC_PAGE_BYTES; b++)
    begin
      if (erase_i[b] || write_i[b])
      begin
        mem[{page_i, 2'(b)}] <= (erase_i[b] ? 8'h00 : mem[{page_i, 2'(b)}])
                                | (write_i[b] ? data_i[8*b +: 8] : 8'h00);
      end
    end
  end

  // Write without erase never clears a bit
  a_or_write : assert property (@(posedge clk_sys_i)
    (write_i[0] && !erase_i[0]) |=> mem[$past({page_i, 2'b00})] ==
      ($past(mem[{page_i, 2'b00}]) | $past(data_i[7:0])))
    else $error("stored byte not ORed with latch");

endmodule

// ===== verilog/nvmtc_counter.sv
// Prescaled 8-bit reload down-counter
`timescale 1ns/1ps
module nvmtc_counter
  import nvmtc_pkg::*;
#(
  parameter int TICK_CYC = NVMTC_TICK_CYC
)
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       run_i,
  input  wire logic       load_i,
  input  wire logic [7:0] reload_i,
  output logic      [7:0] count_o,
  output logic            uf_o
);

  // Prescaler must fit its 16-bit counter
  if (TICK_CYC < 1 || TICK_CYC > 65536)
  begin : g_bad_tick
    $error("TICK_CYC out of range");
  end

  typedef struct packed {
    logic [15:0] pre;
    logic [7:0]  count;
    logic        uf;
  } nvmtc_cnt_t;

  nvmtc_cnt_t r;
  nvmtc_cnt_t next_r;

  // ----------------------------------------------------------------
  // Prescaler, decrement, reload on underflow
  // ----------------------------------------------------------------
  always_comb
  begin
    next_r    = r;
    next_r.uf = 1'b0;
    if (load_i)
    begin
      next_r.count = reload_i;
      next_r.pre   = '0;
    end
    else if (run_i)
    begin
      if (r.pre == 16'(TICK_CYC - 1))
      begin
        next_r.pre = '0;
        if (r.count == 8'h00)
        begin
          next_r.count = reload_i;
          next_r.uf    = 1'b1;
        end
        else
          next_r.count = r.count - 8'h01;
      end
      else
        next_r.pre = r.pre + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      r <= '0;
    else
      r <= next_r;
  end

  assign count_o = r.count;
  assign uf_o    = r.uf;

  a_hold_stopped : assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (!run_i && !load_i) |=> $stable(r.count))
    else $error("stopped counter changed");
  a_reload_uf : assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(r.uf) |-> r.count == $past(reload_i))
    else $error("underflow did not reload");

endmodule

// ===== verilog/nvmtc_top.sv
// Nonvolatile store control with reload down-counter timing
//
// How it works
// - 256 bytes as 64 four-byte pages
// - Page ops in parallel, bytes picked by flags
// - Writes OR new data into stored byte
// - Reads immediate; erase and write take 5 ms
// - Address register advances automatically
// - 8-bit down-counter with reload register
// - Counter also usable for general timing
// - Bit 7 runs counter, else holds outside a program cycle
// - Bit 6 gates underflow interrupt
// - Bit 5 underflow flag, software clears only
// - Bit 4 starts cycle, cleared when done
// - Program bit plus three mode bits select access
// - Bit 0 always reads zero
// - Erase/write is erase then write, double time
// - Address increments after read/write, not erase
// - Cycle end clears bit 4, may interrupt
`timescale 1ns/1ps
module nvmtc_top
  import nvmtc_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  output logic            irq_o,
  output logic            busy_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]   addr;
    logic         run;
    logic         ien;
    logic         flag;
    logic [2:0]   mode;
    nvmtc_phase_t phase;
    logic [2:0]   op;
    logic [7:0]   reload;
    logic [31:0]  latch;
    logic [3:0]   sel;
    logic         load;
    logic [7:0]   rdata;
    logic         irq;
    logic         busy;
  } nvmtc_state_t;

  nvmtc_state_t r;
  nvmtc_state_t next_r;

  logic [7:0]  mem_rdata;
  logic [7:0]  count;
  logic        uf;
  logic [3:0]  erase_mask;
  logic [3:0]  write_mask;
  logic        cyc_end;
  logic        cyc_mid;
  logic        start_req;
  logic [7:0]  ctrl_rd;

  // Program modes that may be started
  function automatic logic prog_valid(input logic [2:0] m);
    prog_valid = (m[2:1] == NVMTC_MODE_WRPAGE) || (m == NVMTC_MODE_ERWR)
                 || (m == NVMTC_MODE_ERASE);
  endfunction

  // Control register image
  function automatic logic [7:0] ctrl_image(input nvmtc_state_t s);
    ctrl_image = {s.run, s.ien, s.flag, s.phase != NVMTC_PH_IDLE, s.mode, 1'b0};
  endfunction

  // Page geometry must tile the store exactly
  if (NVMTC_PAGES * NVMTC_PAGE_BYTES != NVMTC_BYTES)
  begin : g_bad_geometry
    $error("page geometry does not cover the store");
  end

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  nvmtc_store u_store (
    .clk_sys_i (clk_sys_i),
    .raddr_i   (r.addr),
    .rdata_o   (mem_rdata),
    .page_i    (r.addr[7:2]),
    .erase_i   (erase_mask),
    .write_i   (write_mask),
    .data_i    (r.latch)
  );

  nvmtc_counter #(
    .TICK_CYC (NVMTC_TICK_CYC)
  ) u_counter (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .run_i     (r.run || (r.phase != NVMTC_PH_IDLE)),
    .load_i    (r.load),
    .reload_i  (r.reload),
    .count_o   (count),
    .uf_o      (uf)
  );

  // ----------------------------------------------------------------
  // Cycle end decode and page commands
  // ----------------------------------------------------------------
  always_comb
  begin
    cyc_mid    = uf && (r.phase == NVMTC_PH_FIRST) && (r.op == NVMTC_MODE_ERWR);
    cyc_end    = uf && (r.phase != NVMTC_PH_IDLE) && !cyc_mid;
    erase_mask = 4'h0;
    write_mask = 4'h0;
    if (cyc_mid || (cyc_end && r.op == NVMTC_MODE_ERASE))
      erase_mask = r.sel;
    if (cyc_end && r.op != NVMTC_MODE_ERASE)
      write_mask = r.sel;
    start_req  = wr_i && (addr_i == NVMTC_CTRL_OFS) && wdata_i[NVMTC_PROG_BIT]
                 && (r.phase == NVMTC_PH_IDLE);
    ctrl_rd    = ctrl_image(r);
  end

  // ----------------------------------------------------------------
  // Register writes, reads and sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    next_r      = r;
    next_r.load = 1'b0;

    // Register writes
    if (wr_i)
    begin
      case (addr_i)
        NVMTC_ADDR_OFS:
        begin
          next_r.addr = wdata_i;
        end
        NVMTC_DATA_OFS:
        begin
          if (r.phase == NVMTC_PH_IDLE)
          begin
            next_r.latch[8*r.addr[1:0] +: 8] = r.latch[8*r.addr[1:0] +: 8] | wdata_i;
            next_r.sel[r.addr[1:0]]          = 1'b1;
            if (r.mode == NVMTC_MODE_INCR && r.addr[1:0] != 2'h3)
              next_r.addr[1:0] = r.addr[1:0] + 2'h1;
          end
        end
        NVMTC_CTRL_OFS:
        begin
          next_r.run  = wdata_i[NVMTC_RUN_BIT];
          next_r.ien  = wdata_i[NVMTC_IEN_BIT];
          next_r.flag = wdata_i[NVMTC_FLAG_BIT];
          next_r.mode = wdata_i[NVMTC_MODE_MSB:NVMTC_MODE_LSB];
          if (wdata_i[NVMTC_RUN_BIT] && !r.run)
            next_r.load = 1'b1;
        end
        NVMTC_RELOAD_OFS:
        begin
          next_r.reload = wdata_i;
        end
        default:
        begin
          next_r.rdata = r.rdata;
        end
      endcase
    end

    // Start of a program cycle
    if (start_req)
    begin
      if (prog_valid(wdata_i[NVMTC_MODE_MSB:NVMTC_MODE_LSB]))
      begin
        next_r.phase = NVMTC_PH_FIRST;
        next_r.op    = wdata_i[NVMTC_MODE_MSB:NVMTC_MODE_LSB];
        next_r.load  = 1'b1;
      end
      else
        next_r.phase = NVMTC_PH_IDLE;
    end

    // Sequencer
    case (r.phase)
      NVMTC_PH_IDLE:
      begin
        next_r.op = start_req ? next_r.op : r.op;
      end
      NVMTC_PH_FIRST:
      begin
        if (cyc_mid)
          next_r.phase = NVMTC_PH_SECOND;
      end
      NVMTC_PH_SECOND:
      begin
        next_r.phase = NVMTC_PH_SECOND;
      end
      default:
      begin
        next_r.phase = NVMTC_PH_IDLE;
      end
    endcase

    if (cyc_end)
    begin
      next_r.phase = NVMTC_PH_IDLE;
      next_r.latch = '0;
      next_r.sel   = '0;
      if (r.op != NVMTC_MODE_ERASE)
        next_r.addr = r.addr + 8'h01;
    end

    // Underflow sets the flag and wins over a software clear
    if (uf)
      next_r.flag = 1'b1;

    // Reads: data stand in the cycle after the strobe
    next_r.rdata = 8'h00;
    if (rd_i)
    begin
      case (addr_i)
        NVMTC_ADDR_OFS:   next_r.rdata = r.addr;
        NVMTC_DATA_OFS:
        begin
          next_r.rdata = mem_rdata;
          if (r.phase == NVMTC_PH_IDLE && r.mode == NVMTC_MODE_READ)
            next_r.addr = r.addr + 8'h01;
        end
        NVMTC_CTRL_OFS:   next_r.rdata = ctrl_rd;
        NVMTC_RELOAD_OFS: next_r.rdata = r.reload;
        NVMTC_COUNT_OFS:  next_r.rdata = count;
        default:          next_r.rdata = 8'h00;
      endcase
    end

    // Interrupt request gated by enable
    next_r.irq = next_r.flag && next_r.ien;

    // Busy mirrors the program phase, kept in a flop for the pin
    next_r.busy = (next_r.phase != NVMTC_PH_IDLE);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      r        <= '0;
      r.reload <= NVMTC_RELOAD_RST;
      r.phase  <= NVMTC_PH_IDLE;
    end
    else
      r <= next_r;
  end

  assign rdata_o = r.rdata;
  assign irq_o   = r.irq;
  assign busy_o  = r.busy;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  // Register read port
  a_bit0_zero : assert property (
    (rd_i && addr_i == NVMTC_CTRL_OFS) |=> !rdata_o[0])
    else $error("control bit 0 read as one");
  a_rdata_quiet : assert property (
    !rd_i |=> rdata_o == 8'h00)
    else $error("read data stood without a read");
  a_read_incr : assert property (
    (rd_i && !wr_i && addr_i == NVMTC_DATA_OFS && !busy_o && r.mode == NVMTC_MODE_READ)
      |=> r.addr == $past(r.addr) + 8'h01)
    else $error("address not advanced after read");

  // Page setup
  a_incr_stop : assert property (
    (wr_i && addr_i == NVMTC_DATA_OFS && !busy_o && r.mode == NVMTC_MODE_INCR
      && r.addr[1:0] == 2'h3) |=> $stable(r.addr))
    else $error("latch subcounter passed the last latch");
  a_setup_busy : assert property (
    (wr_i && addr_i == NVMTC_DATA_OFS && busy_o && !uf) |=> $stable(r.sel))
    else $error("page setup changed during a cycle");

  // Flag, interrupt and counter load
  a_flag_on_uf : assert property (uf |=> r.flag)
    else $error("underflow did not set flag");
  a_flag_sticky : assert property (
    (r.flag && !(wr_i && addr_i == NVMTC_CTRL_OFS)) |=> r.flag)
    else $error("flag cleared without software");
  a_flag_sw_set : assert property (
    (wr_i && addr_i == NVMTC_CTRL_OFS && wdata_i[NVMTC_FLAG_BIT]) |=> r.flag)
    else $error("software could not set flag");
  a_irq_gate : assert property (irq_o == (r.flag && r.ien))
    else $error("interrupt not gated by enable");
  a_run_load : assert property (
    (wr_i && addr_i == NVMTC_CTRL_OFS && wdata_i[NVMTC_RUN_BIT] && !r.run) |=> r.load)
    else $error("counter not loaded on run");

  // Program cycle
  a_busy_image : assert property (busy_o == ctrl_rd[NVMTC_PROG_BIT])
    else $error("busy pin and program bit disagree");
  a_start_load : assert property (
    (start_req && prog_valid(wdata_i[NVMTC_MODE_MSB:NVMTC_MODE_LSB])) |=> busy_o && r.load)
    else $error("start did not begin cycle");
  a_no_restart : assert property (
    (wr_i && addr_i == NVMTC_CTRL_OFS && busy_o && !uf) |=> $stable(r.phase) && $stable(r.op))
    else $error("control write disturbed a running cycle");
  a_bad_mode : assert property (
    (start_req && !prog_valid(wdata_i[NVMTC_MODE_MSB:NVMTC_MODE_LSB])) |=> !busy_o)
    else $error("disallowed mode started a cycle");
  a_erase_sel : assert property (
    (cyc_end && r.op == NVMTC_MODE_ERASE) |-> erase_mask == r.sel && write_mask == 4'h0)
    else $error("erase page touched unselected bytes");
  a_write_sel : assert property (
    (cyc_end && r.op != NVMTC_MODE_ERASE) |-> write_mask == r.sel && erase_mask == 4'h0)
    else $error("write page touched unselected bytes");
  a_erwr_two : assert property (cyc_mid |=> busy_o && r.phase == NVMTC_PH_SECOND)
    else $error("erase/write ended after one period");
  a_end_clears : assert property (cyc_end |=> !busy_o && !ctrl_rd[NVMTC_PROG_BIT])
    else $error("program bit not cleared at end");
  a_latch_clear : assert property (
    cyc_end |=> r.sel == 4'h0 && r.latch == 32'h00000000)
    else $error("latches survived the cycle end");

  // Address after a cycle
  a_erase_addr : assert property (
    (cyc_end && r.op == NVMTC_MODE_ERASE && !wr_i && !rd_i) |=> $stable(r.addr))
    else $error("address moved after erase");
  a_write_addr : assert property (
    (cyc_end && r.op != NVMTC_MODE_ERASE && !wr_i) |=> r.addr == $past(r.addr) + 8'h01)
    else $error("address not advanced after write");

endmodule

// ===== tb/nvmtc_top_tb.sv
// Self-checking bench for the store control and reload down-counter block
`timescale 1ns/1ps
module nvmtc_top_tb
  import nvmtc_pkg::*;
;
  logic       clk_sys_i;
  logic       rst_i;
  logic [7:0] addr_i;
  logic [7:0] wdata_i;
  logic       wr_i;
  logic       rd_i;
  logic [7:0] rdata_o;
  logic       irq_o;
  logic       busy_o;
  int         mismatches;
  int         num_checks;
  int         cycles;
  int         n;
  logic [7:0] v;

  nvmtc_top i_nvmtc_top (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .addr_i    (addr_i),
    .wdata_i   (wdata_i),
    .wr_i      (wr_i),
    .rd_i      (rd_i),
    .rdata_o   (rdata_o),
    .irq_o     (irq_o),
    .busy_o    (busy_o)
  );

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  // Cuts a hang short
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      mismatches++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i    <= 1'b0;
  endtask

  // One-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i   <= 1'b0;
    @(negedge clk_sys_i);
    d = rdata_o;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  // Start a cycle and time it until busy drops
  task automatic go(input logic [7:0] ctrl, input int lo, input int hi);
    wr(NVMTC_CTRL_OFS, ctrl);
    @(negedge clk_sys_i);
    chk({7'h00, busy_o}, 8'h01);
    n = 0;
    while (busy_o === 1'b1 && n < 5000)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    chk({7'h00, n >= lo && n <= hi}, 8'h01);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk({6'h00, irq_o, busy_o}, 8'h00);
    rdc(NVMTC_CTRL_OFS, NVMTC_CTRL_RST);
    rdc(NVMTC_RELOAD_OFS, NVMTC_RELOAD_RST);
    rdc(NVMTC_ADDR_OFS, 8'h00);
    rdc(8'h07, 8'h00);
    $display("t_reset done");
  endtask

  task automatic t_ctrl;
    wr(NVMTC_CTRL_OFS, 8'h2f);
    rdc(NVMTC_CTRL_OFS, 8'h2e);
    chk({7'h00, irq_o}, 8'h00);
    wr(NVMTC_CTRL_OFS, 8'h60);
    repeat (2) @(negedge clk_sys_i);
    chk({7'h00, irq_o}, 8'h01);
    wr(NVMTC_CTRL_OFS, 8'h40);
    repeat (2) @(negedge clk_sys_i);
    chk({7'h00, irq_o}, 8'h00);
    rdc(NVMTC_CTRL_OFS, 8'h40);
    wr(NVMTC_CTRL_OFS, 8'h00);
    $display("t_ctrl done");
  endtask

  task automatic t_page;
    logic [7:0] exp [4];
    wr(NVMTC_RELOAD_OFS, 8'h02);
    rdc(NVMTC_RELOAD_OFS, 8'h02);
    wr(NVMTC_ADDR_OFS, 8'h08);
    wr(NVMTC_CTRL_OFS, 8'h04);
    for (int i = 0; i < 4; i++)
      wr(NVMTC_DATA_OFS, 8'hff);
    rdc(NVMTC_ADDR_OFS, 8'h0b);
    go(8'h1e, 1000, 1600);
    rdc(NVMTC_ADDR_OFS, 8'h0b);
    wr(NVMTC_ADDR_OFS, 8'h08);
    wr(NVMTC_CTRL_OFS, 8'h00);
    for (int i = 0; i < 4; i++)
      rdc(NVMTC_DATA_OFS, 8'h00);
    // Fill the page, then OR into one byte
    wr(NVMTC_CTRL_OFS, 8'h04);
    wr(NVMTC_ADDR_OFS, 8'h08);
    for (int i = 1; i < 5; i++)
      wr(NVMTC_DATA_OFS, 8'h11 * i[7:0]);
    go(8'h14, 1000, 1600);
    rdc(NVMTC_ADDR_OFS, 8'h0c);
    rdc(NVMTC_CTRL_OFS, 8'h24);
    wr(NVMTC_ADDR_OFS, 8'h09);
    wr(NVMTC_DATA_OFS, 8'h0c);
    go(8'h16, 1000, 1600);
    wr(NVMTC_ADDR_OFS, 8'h0a);
    wr(NVMTC_DATA_OFS, 8'h05);
    go(8'h18, 2500, 3200);
    exp = '{8'h11, 8'h2e, 8'h05, 8'h44};
    wr(NVMTC_CTRL_OFS, 8'h00);
    wr(NVMTC_ADDR_OFS, 8'h08);
    for (int i = 0; i < 4; i++)
      rdc(NVMTC_DATA_OFS, exp[i]);
    $display("t_page done");
  endtask

  task automatic t_refuse;
    logic [7:0] codes [3];
    codes = '{8'h12, 8'h1a, 8'h1c};
    wr(NVMTC_ADDR_OFS, 8'h08);
    wr(NVMTC_DATA_OFS, 8'hff);
    foreach (codes[i])
    begin
      wr(NVMTC_CTRL_OFS, codes[i]);
      @(negedge clk_sys_i);
      chk({7'h00, busy_o}, 8'h00);
    end
    wr(NVMTC_CTRL_OFS, 8'h00);
    wr(NVMTC_ADDR_OFS, 8'h08);
    rdc(NVMTC_DATA_OFS, 8'h11);
    $display("t_refuse done");
  endtask

  task automatic t_counter;
    wr(NVMTC_RELOAD_OFS, 8'h03);
    wr(NVMTC_CTRL_OFS, 8'hc0);
    repeat (600) @(negedge clk_sys_i);
    chk({7'h00, irq_o}, 8'h00);
    repeat (2000) @(negedge clk_sys_i);
    chk({7'h00, irq_o}, 8'h01);
    rdc(NVMTC_CTRL_OFS, 8'he0);
    rd(NVMTC_COUNT_OFS, v);
    chk({7'h00, v <= 8'h03}, 8'h01);
    wr(NVMTC_CTRL_OFS, 8'h00);
    rd(NVMTC_COUNT_OFS, v);
    repeat (1200) @(negedge clk_sys_i);
    rdc(NVMTC_COUNT_OFS, v);
    $display("t_counter done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    mismatches = 0;
    num_checks = 0;
    cycles     = 0;
    rst_i      = 1'b1;
    addr_i     = 8'h00;
    wdata_i    = 8'h00;
    wr_i       = 1'b0;
    rd_i       = 1'b0;
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(negedge clk_sys_i);
    t_reset();
    t_ctrl();
    t_page();
    t_refuse();
    t_counter();
    test_done();
  end
endmodule
